// ---- src/ee_front.sv ----
// Functional notes
// - array of 16K bytes, byte addressed
// - 64-byte id page, lockable to read-only
// - bus clock samples and times data line
// - data line only pulled low or released
// - chip selects match select bits b3..b1
// - unconnected chip select reads as zero (no pull-down here: the board must pull an open pin to 0)
// - five-lead variant uses chip select 000
// - write protect high blocks array writes
// - write protect low or open allows writes (no pull-down here: the board must pull an open wp low)
// - protected: ack select/address, nack data
// - no response until power-on reset released
// - reset clears state, enters standby
// - supply loss stops all bus responses
// - stop without write cycle gives standby
// - respond only on matching select, else standby
// - stop after write data starts programming
// - programming releases line, ignores bus
`timescale 1ns/10ps
`include "ee_params.svh"

module ee_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // fill side
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  // drain side
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  buf_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  wire           push = i_valid & o_ready;
  wire           pop  = o_valid & i_ready;

  assign o_ready = cnt_ff != (AW+1)'(D);
  assign o_valid = cnt_ff != '0;
  assign o_data  = buf_ff[rd_ff];

  always_ff @(posedge i_clk) begin
    if (push) begin
      buf_ff[wr_ff] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= wr_ff + AW'(push);
      rd_ff  <= rd_ff + AW'(pop);
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ee_front
  import ee_pkg::*;
#(
  parameter bit FIVE_LEAD = 1'b0,
  parameter int TW_CYC    = `EE_TW_NS / `EE_CLK_NS
) (
  // clock and power-on reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // two-wire bus pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda,
  output logic      o_sda_oe,
  // board straps
  input  wire logic i_chip_select_bit2,
  input  wire logic i_chip_select_bit1,
  input  wire logic i_chip_select_bit0,
  input  wire logic i_write_protect_input,
  // status
  output logic      o_busy,
  output logic      o_standby
);
  function automatic logic dev_hit(input logic [7:0] b,
                                   input logic [2:0] cs);
    dev_hit = (b[7:5] == `EE_TYPE_HI) && (b[3:1] == cs);
  endfunction

  logic [7:0]           mem    [`EE_MEM_DEPTH];
  logic [7:0]           id_mem [`EE_ID_DEPTH];
  logic [7:0]           pg_ff  [`EE_ID_DEPTH];
  logic [63:0]          pgv_ff;
  logic [7:0]           pg_hi_ff;
  logic                 pg_id_ff;
  logic                 pg_lock_ff;
  logic                 lock_ff;
  logic [5:0]           meta_ff;
  logic [5:0]           sync_ff;
  logic                 scl_d_ff;
  logic                 sda_d_ff;
  ee_state_t            st_ff;
  logic [3:0]           bit_ff;
  logic [7:0]           sh_ff;
  logic [7:0]           rd_ff;
  logic [13:0]          addr_ff;
  logic                 idp_ff;
  logic                 pull_ff;
  logic                 acked_ff;
  logic [`EE_CNT_W-1:0] prog_cnt_ff;
  logic                 fifo_rdy;
  logic                 drain_vld;
  ee_wr_t               drain_w;

  // straps are meant to be tied; an open pin must be pulled to 0 on board
  wire       scl       = sync_ff[5];
  wire       sda       = sync_ff[4];
  wire       wp        = sync_ff[3];
  wire [2:0] cs_val    = FIVE_LEAD ? 3'h0 : sync_ff[2:0];
  wire       scl_rise  = scl & ~scl_d_ff;
  wire       scl_fall  = ~scl & scl_d_ff;
  wire       bus_start = scl & scl_d_ff & sda_d_ff & ~sda;
  wire       bus_stop  = scl & scl_d_ff & ~sda_d_ff & sda;
  wire       rx_rise   = scl_rise & (bit_ff < `EE_BIT_ACK);
  wire       slot_ack  = scl_fall & (bit_ff == `EE_BIT_ACK);
  wire       slot_end  = scl_fall & (bit_ff == `EE_BIT_END);
  wire       hit       = dev_hit(sh_ff, cs_val);
  wire       in_prog   = st_ff == EE_PROG;
  // wp low or open (pulled low) lets data through
  wire       refuse    = wp | ~fifo_rdy | (idp_ff & lock_ff);
  wire       push      = slot_ack & (st_ff == EE_WD) & ~refuse;
  wire       commit    = bus_stop & (st_ff == EE_WD) & acked_ff;
  wire [7:0] rd_byte   = idp_ff ? id_mem[addr_ff[5:0]] : mem[addr_ff];
  wire [5:0] pidx      = prog_cnt_ff[5:0];
  wire       prog_we   = in_prog & (prog_cnt_ff < `EE_PAGE_LEN) &
                         pgv_ff[pidx];
  wire       prog_done = in_prog &
                         (prog_cnt_ff == `EE_CNT_W'(TW_CYC - 1));
  wire [13:0] pg_roll  = {addr_ff[13:6], addr_ff[5:0] + 6'h01};
  ee_wr_t    push_w;

  assign push_w.idp  = idp_ff;
  assign push_w.lock = idp_ff & addr_ff[`EE_LOCK_BIT];
  assign push_w.addr = addr_ff;
  assign push_w.data = sh_ff;
  assign o_sda       = 1'b0;
  assign o_sda_oe    = pull_ff;
  assign o_busy      = in_prog;
  assign o_standby   = st_ff == EE_IDLE;

  // pins cross into i_clk; only sync_ff is read by logic
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_ff  <= `EE_SYNC_RST;
      sync_ff  <= `EE_SYNC_RST;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      meta_ff  <= {i_scl, i_sda, i_write_protect_input,
                   i_chip_select_bit2, i_chip_select_bit1,
                   i_chip_select_bit0};
      sync_ff  <= meta_ff;
      scl_d_ff <= sync_ff[5];
      sda_d_ff <= sync_ff[4];
    end
  end

  // received write bytes wait here until they land in the page latch
  ee_fifo #(
    .W($bits(ee_wr_t)),
    .D(`EE_FIFO_DEPTH)
  ) u_fifo (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_valid(push),
    .o_ready(fifo_rdy),
    .i_data (push_w),
    .o_valid(drain_vld),
    .i_ready(~in_prog),
    .o_data (drain_w)
  );

  // bus state machine; reset doubles as the power-on detector
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_ff    <= EE_IDLE;
      bit_ff   <= '0;
      sh_ff    <= '0;
      rd_ff    <= '0;
      addr_ff  <= '0;
      idp_ff   <= 1'b0;
      pull_ff  <= 1'b0;
      acked_ff <= 1'b0;
    end else if (in_prog) begin
      pull_ff <= 1'b0;
      if (prog_done) begin
        st_ff <= EE_IDLE;
      end
    end else if (bus_start) begin
      st_ff    <= EE_DEV;
      bit_ff   <= '0;
      pull_ff  <= 1'b0;
      acked_ff <= 1'b0;
    end else if (bus_stop) begin
      st_ff   <= commit ? EE_PROG : EE_IDLE;
      pull_ff <= 1'b0;
    end else if (st_ff != EE_IDLE) begin
      if (rx_rise) begin
        sh_ff  <= {sh_ff[6:0], sda};
        bit_ff <= bit_ff + 4'h1;
      end else if (scl_rise) begin
        bit_ff <= `EE_BIT_END;
        if (st_ff == EE_RD && sda) begin
          st_ff <= EE_IDLE;
        end
      end else if (slot_ack) begin
        unique case (st_ff)
          EE_DEV: begin
            pull_ff <= hit;
            idp_ff  <= sh_ff[`EE_ID_SEL_BIT];
            st_ff   <= !hit ? EE_IDLE : sh_ff[0] ? EE_RD : EE_AH;
          end
          EE_AH: begin
            pull_ff        <= 1'b1;
            addr_ff[13:8] <= sh_ff[5:0];
            st_ff          <= EE_AL;
          end
          EE_AL: begin
            pull_ff       <= 1'b1;
            addr_ff[7:0] <= sh_ff;
            st_ff         <= EE_WD;
          end
          EE_WD: begin
            pull_ff  <= ~refuse;
            acked_ff <= ~refuse;
            if (!refuse) begin
              addr_ff <= pg_roll;
            end
          end
          default: pull_ff <= 1'b0;
        endcase
      end else if (slot_end) begin
        bit_ff  <= '0;
        pull_ff <= (st_ff == EE_RD) ? ~rd_byte[7] : 1'b0;
        if (st_ff == EE_RD) begin
          rd_ff   <= rd_byte;
          addr_ff <= addr_ff + 14'h0001;
        end
      end else if (scl_fall) begin
        acked_ff <= 1'b0;
        if (st_ff == EE_RD) begin
          pull_ff <= ~rd_ff[3'h7 - bit_ff[2:0]];
        end
      end
    end
  end

  // page latch: a whole page commits in one write cycle
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pgv_ff     <= '0;
      pg_hi_ff   <= '0;
      pg_id_ff   <= 1'b0;
      pg_lock_ff <= 1'b0;
      lock_ff    <= 1'b0;
    end else if (prog_done) begin
      pgv_ff     <= '0;
      pg_lock_ff <= 1'b0;
      lock_ff    <= lock_ff | pg_lock_ff;
    end else if (drain_vld && !in_prog) begin
      pgv_ff[drain_w.addr[5:0]] <= ~drain_w.lock;
      pg_hi_ff   <= drain_w.addr[13:6];
      pg_id_ff   <= drain_w.idp;
      pg_lock_ff <= pg_lock_ff | drain_w.lock;
    end
  end

  always_ff @(posedge i_clk) begin
    if (drain_vld && !in_prog) begin
      pg_ff[drain_w.addr[5:0]] <= drain_w.data;
    end
    if (prog_we && !pg_id_ff) begin
      mem[{pg_hi_ff, pidx}] <= pg_ff[pidx];
    end
    if (prog_we && pg_id_ff) begin
      id_mem[pidx] <= pg_ff[pidx];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst || !in_prog) begin
      prog_cnt_ff <= '0;
    end else begin
      prog_cnt_ff <= prog_cnt_ff + `EE_CNT_W'(1);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  line_low_a: assert property (o_sda == 1'b0)
    else $error("data line driven high");
  prog_quiet_a: assert property (in_prog |-> !o_sda_oe)
    else $error("line pulled during write cycle");
  wp_nack_a: assert property (st_ff == EE_WD && slot_ack && wp
      |=> !o_sda_oe && !acked_ff)
    else $error("protected data byte acknowledged");
  sel_ack_a: assert property (st_ff == EE_DEV && slot_ack
      && dev_hit(sh_ff, cs_val) |=> o_sda_oe ##1 o_sda_oe)
    else $error("matching select not acknowledged");
  sel_miss_a: assert property (st_ff == EE_DEV && slot_ack
      && !dev_hit(sh_ff, cs_val) |=> o_standby && !o_sda_oe)
    else $error("mismatched select not ignored");
  strap_zero_a: assert property (!FIVE_LEAD || cs_val == 3'h0)
    else $error("five-lead select not zero");
  stop_prog_a: assert property (commit && !in_prog
      |=> o_busy [*8])
    else $error("write stop did not start programming");
  stop_idle_a: assert property (bus_stop && !commit && !in_prog
      |=> o_standby)
    else $error("stop did not give standby");
  edge_only_a: assert property ($changed(o_sda_oe)
      |-> $past(scl_fall) || $past(bus_start) || $past(bus_stop)
          || $past(in_prog))
    else $error("line changed off a clock fall");
  rst_idle_a: assert property (disable iff (1'b0)
      !i_nrst |=> o_standby && !o_sda_oe && !o_busy)
    else $error("reset did not idle the bus machine");

  cov_read_c:  cover property (st_ff == EE_DEV ##1 st_ff == EE_RD);
  cov_prog_c:  cover property (prog_we);
  cov_wp_c:    cover property (st_ff == EE_WD && slot_ack && wp);
  cov_lock_c:  cover property (prog_done && pg_lock_ff);
endmodule

// ---- src/ee_params.svh ----
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH
// two-wire timing and layout
`define EE_CLK_NS     40
`define EE_TW_NS      5000000
`define EE_CNT_W      17
`define EE_MEM_DEPTH  16'h4000
`define EE_ID_DEPTH   8'h40
`define EE_PAGE_LEN   17'h0_0040
`define EE_FIFO_DEPTH 4
`define EE_TYPE_HI    3'h5
`define EE_ID_SEL_BIT 4
`define EE_LOCK_BIT   10
`define EE_BIT_ACK    4'h8
`define EE_BIT_END    4'h9
`define EE_SYNC_RST   6'h30
`endif

// ---- src/ee_pkg.sv ----
`include "ee_params.svh"
package ee_pkg;
  typedef enum logic [2:0] {
    EE_IDLE = 3'b000,
    EE_DEV  = 3'b001,
    EE_AH   = 3'b010,
    EE_AL   = 3'b011,
    EE_WD   = 3'b100,
    EE_RD   = 3'b101,
    EE_PROG = 3'b110
  } ee_state_t;

  typedef struct packed {
    logic        idp;
    logic        lock;
    logic [13:0] addr;
    logic [7:0]  data;
  } ee_wr_t;
endpackage

// ---- dv/ee_master_model.sv ----
`timescale 1ns/10ps
module ee_master_model (
  // wire as pulled by the blocks
  input  wire logic i_dev_pull,
  // bus pins
  output logic      o_scl,
  output logic      o_sda
);
  logic mclk;
  logic sda_m;

  // own clock, phase unrelated to the block's clock
  initial begin
    mclk = 1'b0;
    o_scl = 1'b1;
    sda_m = 1'b1;
    #7;
    forever #20 mclk = ~mclk;
  end

  // pull-up: a line that nobody pulls reads high
  assign o_sda = sda_m & ~i_dev_pull;

  task automatic hc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic step(input logic c, input logic s, input int n);
    o_scl <= c;
    sda_m <= s;
    hc(n);
  endtask

  // long low phase: the block answers 3 clocks after scl falls
  task automatic bit_io(input logic b, output logic r);
    hc(2);
    step(1'b0, b, 4);
    step(1'b1, b, 2);
    r = o_sda;
    o_scl <= 1'b0;
  endtask

  // let an edge pass first: a bit that just ended lowered scl in this step
  task automatic start;
    hc(2);
    step(1'b0, 1'b1, 4);
    step(1'b1, 1'b1, 4);
    step(1'b1, 1'b0, 4);
    o_scl <= 1'b0;
  endtask

  task automatic stop;
    hc(2);
    step(1'b0, 1'b0, 4);
    step(1'b1, 1'b0, 4);
    step(1'b1, 1'b1, 4);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ---- dv/ee_front_bench.sv ----
`timescale 1ns/10ps
module ee_front_bench;
  localparam int TW = 200;
  logic       i_clk = 1'b0;
  logic       i_nrst, wp, scl, sda, oe1, oe2, sda1, busy, stby;
  logic [2:0] cs, cs5;
  logic [7:0] rd_d;
  int         bad_count = 0;
  int         n_checks = 0;
  int         cyc = 0;

  always #20 i_clk = ~i_clk;

  ee_master_model ee_master_model_i (
    .i_dev_pull(oe1 | oe2), .o_scl(scl), .o_sda(sda));
  ee_front #(.TW_CYC(TW)) ee_front_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
    .o_sda(sda1), .o_sda_oe(oe1), .i_chip_select_bit2(cs[2]),
    .i_chip_select_bit1(cs[1]), .i_chip_select_bit0(cs[0]),
    .i_write_protect_input(wp), .o_busy(busy), .o_standby(stby));
  // five-lead part on the same wire: its high straps must not count
  ee_front #(.FIVE_LEAD(1'b1), .TW_CYC(TW)) ee_front_lead5_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
    .o_sda(), .o_sda_oe(oe2), .i_chip_select_bit2(cs5[2]),
    .i_chip_select_bit1(cs5[1]), .i_chip_select_bit0(cs5[0]),
    .i_write_protect_input(wp), .o_busy(), .o_standby());

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the run needs well under 10000 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  always @(negedge i_clk) if (oe1 === 1'b1) check(8'(sda1), 8'h00);

  task automatic wb(input logic [7:0] d, input logic ack);
    logic a;
    ee_master_model_i.wbyte(d, a);
    check(8'(a), 8'(ack));
  endtask

  task automatic adr(input logic id, input logic [13:0] a);
    ee_master_model_i.start();
    wb({3'h5, id, cs, 1'b0}, 1'b1);
    wb({2'h0, a[13:8]}, 1'b1);
    wb(a[7:0], 1'b1);
  endtask

  task automatic wr(input logic id, input logic [13:0] a,
                    input logic [7:0] d, input logic ack);
    adr(id, a);
    wb(d, ack);
    ee_master_model_i.stop();
  endtask

  task automatic rd(input logic id, input logic [13:0] a,
                    input logic [7:0] exp);
    adr(id, a);
    ee_master_model_i.start();
    wb({3'h5, id, cs, 1'b1}, 1'b1);
    ee_master_model_i.rbyte(1'b1, rd_d);
    ee_master_model_i.stop();
    check(rd_d, exp);
  endtask

  // two bytes in one read: the master acks the first to go on
  task automatic rd2(input logic [13:0] a, input logic [15:0] exp);
    logic [7:0] d0;
    adr(1'b0, a);
    ee_master_model_i.start();
    wb({3'h5, 1'b0, cs, 1'b1}, 1'b1);
    ee_master_model_i.rbyte(1'b0, d0);
    ee_master_model_i.rbyte(1'b1, rd_d);
    ee_master_model_i.stop();
    check(d0, exp[15:8]);
    check(rd_d, exp[7:0]);
  endtask

  // stop is seen 3 clocks late, so give it 4 before polling
  task automatic settle;
    repeat (4) @(negedge i_clk);
    repeat (2 * TW) if (busy !== 1'b0) @(negedge i_clk);
    check(8'(stby), 8'h01);
  endtask

  initial begin
    i_nrst = 1'b0;
    wp = 1'b0;
    cs = 3'h5;
    cs5 = 3'h7;
    repeat (3) @(posedge i_clk);
    check(8'({stby, busy, oe1}), 8'h04);
    i_nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      ee_master_model_i.start();
      wb({4'ha, 3'(i), 1'b0}, i == 5 || i == 0);
      ee_master_model_i.stop();
    end
    settle();
    wr(1'b0, 14'h2345, 8'h5a, 1'b1);
    repeat (4) @(negedge i_clk);
    check(8'({busy, stby}), 8'h02);
    ee_master_model_i.start();
    wb({3'h5, 1'b0, cs, 1'b0}, 1'b0);
    ee_master_model_i.stop();
    settle();
    rd(1'b0, 14'h2345, 8'h5a);
    @(posedge i_clk) wp <= 1'b1;
    wr(1'b0, 14'h2345, 8'ha5, 1'b0);
    settle();
    rd(1'b0, 14'h2345, 8'h5a);
    adr(1'b0, 14'h0100);
    wb(8'h3c, 1'b0);
    @(posedge i_clk) wp <= 1'b0;
    wb(8'hc3, 1'b1);
    ee_master_model_i.stop();
    settle();
    rd(1'b0, 14'h0100, 8'hc3);
    // four bytes through the write buffer, the last two roll over
    adr(1'b0, 14'h013e);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    wb(8'h33, 1'b1);
    wb(8'h44, 1'b1);
    ee_master_model_i.stop();
    settle();
    rd2(14'h013e, 16'h1122);
    rd2(14'h0100, 16'h3344);
    wr(1'b1, 14'h0007, 8'h96, 1'b1);
    settle();
    rd(1'b1, 14'h0007, 8'h96);
    wr(1'b1, 14'h0400, 8'h00, 1'b1);
    settle();
    wr(1'b1, 14'h0007, 8'h69, 1'b0);
    // reset in mid-transfer: silent while held, idle afterwards
    ee_master_model_i.start();
    wb({3'h5, 1'b0, cs, 1'b0}, 1'b1);
    @(posedge i_clk) i_nrst <= 1'b0;
    wb(8'h23, 1'b0);
    ee_master_model_i.stop();
    @(posedge i_clk) i_nrst <= 1'b1;
    settle();
    rd(1'b0, 14'h2345, 8'h5a);
    summarize();
  end
endmodule
